// ==== hdl/fws_pkg.sv ====
// shared constants of the flash write-status link
package fws_pkg;
  // ******************************
  // link geometry
  // ******************************
  localparam int AW = 4;
  localparam int DW = 8;
  localparam int SECT_BITS = 2;
  localparam int N_SECT = 4;
  localparam int CW = 12;
  localparam logic [DW-1:0] ERASED = 8'hFF;
  localparam logic [DW-1:0] BUS_IDLE = 8'hFF;
  // ******************************
  // command codes
  // ******************************
  localparam logic [7:0] CMD_PROGRAM = 8'hA0;
  localparam logic [7:0] CMD_SECT_ERASE = 8'h30;
  localparam logic [7:0] CMD_CHIP_ERASE = 8'h10;
  localparam logic [7:0] CMD_SUSPEND = 8'hB0;
  localparam logic [7:0] CMD_RESUME = 8'h3C;
  localparam logic [7:0] CMD_RESET = 8'hF0;
  // ******************************
  // status bit positions
  // ******************************
  localparam int BIT_POLL = 7;
  localparam int BIT_TOGGLE = 6;
  localparam int BIT_FAIL = 5;
  localparam int BIT_TIMER = 3;
  localparam int BIT_SECT = 2;
  // ******************************
  // timing
  // ******************************
  localparam int MCLK_MHZ = 10;
  localparam int T_PROT_ERASE_US = 100;
  localparam int T_PROT_PROG_US = 1;
  localparam int T_ERASE_WIN_US = 50;
  localparam logic [CW-1:0] CYC_PROT_ERASE = CW'(T_PROT_ERASE_US * MCLK_MHZ);
  localparam logic [CW-1:0] CYC_PROT_PROG = CW'(T_PROT_PROG_US * MCLK_MHZ);
  localparam logic [CW-1:0] CYC_ERASE_WIN = CW'(T_ERASE_WIN_US * MCLK_MHZ);
  localparam logic [1:0] LINK_ACC_CYC = 2'h3;
  // ******************************
  // host registers and codes
  // ******************************
  localparam logic [1:0] REG_CMD = 2'h0;
  localparam logic [1:0] REG_CFG = 2'h1;
  localparam logic [1:0] REG_STAT = 2'h2;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [1:0] OP_READ = 2'h2;
  localparam logic [1:0] OP_POLL = 2'h3;
  localparam logic [1:0] RES_NONE = 2'h0;
  localparam logic [1:0] RES_DONE = 2'h1;
  localparam logic [1:0] RES_RUNNING = 2'h2;
  localparam logic [1:0] RES_FAILED = 2'h3;
  typedef enum logic [2:0] {
    FS_READ = 3'h0, FS_PROG = 3'h1, FS_PROT = 3'h3, FS_FAIL = 3'h2,
    FS_ERASE_WIN = 3'h6, FS_ERASE = 3'h7, FS_SUSP = 3'h5, FS_SUSP_PROG = 3'h4
  } fws_dev_e;
  typedef enum logic [1:0] {
    HS_IDLE = 2'h0, HS_ACC = 2'h1, HS_GAP = 2'h3
  } fws_host_e;
endpackage

// ==== hdl/fws_link_if.sv ====
// parallel flash link between host end and device end
`timescale 1ns/100ps
`default_nettype none
interface fws_link_if;
  import fws_pkg::*;
  logic ce_n;
  logic oe_n;
  logic we_n;
  logic address_valid_n;
  logic lclk;
  logic [AW-1:0] addr;
  logic [DW-1:0] h_dq;
  logic h_dq_oe;
  logic [DW-1:0] d_dq;
  logic d_dq_oe;
  logic rb_oe;
  wire [DW-1:0] dq;
  wire ready_busy_n;
  // pull-up on both open lines
  assign dq = d_dq_oe ? d_dq : (h_dq_oe ? h_dq : BUS_IDLE);
  assign ready_busy_n = ~rb_oe;
  modport dev (
    input ce_n, oe_n, we_n, address_valid_n, lclk, addr, dq,
    output d_dq, d_dq_oe, rb_oe
  );
  modport host (
    output ce_n, oe_n, we_n, address_valid_n, lclk, addr, h_dq, h_dq_oe,
    input dq, ready_busy_n
  );
endinterface
`default_nettype wire

// ==== hdl/fws_dev_end.sv ====
// flash device end: embedded algorithms and write-status reporting
// ******************************
// Overview of operation
// - toggle bit flips each read while busy
// - toggle valid from last write strobe
// - read cycles bounded by strobes or address-valid
// - all-protected erase toggles 100 us, no erase
// - erase skips protected sectors
// - erase suspend freezes toggle bit
// - protected program toggles 1 us, outside erase suspend
// - suspended-erase program toggles until done
// - sector toggle flips in selected sectors
// - sector toggle valid after last strobe
// - host compares two reads for completion
// - host rechecks toggle when timeout set
// - host restarts polling from first step
// - timeout flag high on pulse limit
// - programming one over zero fails
// - host resets device after failure
// - erase timer low in window, restartable
// - host may skip timer below 50 us
// - after window only suspend is accepted
// - host checks timer around extra erases
// - suspended-sector reads give poll bit high, frozen toggle, flipping sector toggle
// - host polls at a valid sector address
// - ready/busy low while busy, released otherwise
// ******************************
//
// Implementation choices: the Avalon-MM interface to the registers and the address map.
`timescale 1ns/100ps
`default_nettype none
module fws_dev_end
  import fws_pkg::*;
#(
  parameter int PROG_CYC = 20,
  parameter int ERASE_CYC = 200
) (
  input wire logic mclk,
  input wire logic rst_n,
  fws_link_if.dev link,
  input wire logic sync_mode,
  input wire logic [N_SECT-1:0] sector_protect,
  output logic busy,
  output logic failed
);
  localparam int DEPTH = 1 << AW;

  // ******************************
  // helpers
  // ******************************
  function automatic logic [SECT_BITS-1:0] sect_of(input logic [AW-1:0] a);
    sect_of = a[AW-1 -: SECT_BITS];
  endfunction

  fws_dev_e state_reg;
  logic [CW-1:0] cnt_reg;
  logic [DW-1:0] arr_reg [DEPTH];
  logic [N_SECT-1:0] sel_reg;
  logic arm_reg;
  logic [AW-1:0] paddr_reg;
  logic [DW-1:0] pdata_reg;
  logic tog_reg;
  logic stog_reg;
  logic we_q;
  logic ce_q;
  logic rd_q;
  logic adv_q;
  logic lclk_q;
  logic [DW-1:0] wdat_q;
  logic [DW-1:0] dq_reg;
  logic dq_oe_reg;
  logic rb_oe_reg;

  // ******************************
  // strobe edges
  // ******************************
  logic rd_act;
  logic rd_evt;
  logic wr_take;
  logic [DW-1:0] cmd;
  logic prot_hit;
  logic all_prot;
  logic bad_prog;
  logic in_sel;

  assign rd_act = !link.ce_n && !link.oe_n;
  // async: cycle ends on OE or CE rising; sync: address-valid or clock edge
  assign rd_evt = sync_mode ?
    (!link.ce_n && ((!adv_q && link.address_valid_n) ||
                    (!lclk_q && link.lclk && !link.address_valid_n))) :
    (rd_q && !rd_act);
  // command data is latched on the rising write strobe
  assign wr_take = !we_q && !ce_q && link.we_n;
  // host lets go of dq with the strobe, so take the byte seen while we_n was low
  assign cmd = wdat_q;
  assign prot_hit = sector_protect[sect_of(link.addr)];
  assign in_sel = sel_reg[sect_of(link.addr)];
  assign bad_prog = |(~arr_reg[paddr_reg] & pdata_reg);

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      we_q <= 1'b1;
      ce_q <= 1'b1;
      rd_q <= 1'b0;
      adv_q <= 1'b1;
      lclk_q <= 1'b0;
      wdat_q <= '0;
    end else begin
      we_q <= link.we_n;
      wdat_q <= link.dq;
      ce_q <= link.ce_n;
      rd_q <= rd_act;
      adv_q <= link.address_valid_n;
      lclk_q <= link.lclk;
    end
  end

  // ******************************
  // erase selection
  // ******************************
  always_comb begin
    all_prot = &(~sel_reg | sector_protect);
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sel_reg <= '0;
    end else if (wr_take && !arm_reg) begin
      if (state_reg == FS_READ && cmd == CMD_SECT_ERASE) begin
        sel_reg <= '0;
        sel_reg[sect_of(link.addr)] <= 1'b1;
      end else if (state_reg == FS_ERASE_WIN && cmd == CMD_SECT_ERASE) begin
        sel_reg[sect_of(link.addr)] <= 1'b1;
      end else if (state_reg == FS_READ && cmd == CMD_CHIP_ERASE) begin
        sel_reg <= '1;
      end
    end else if (state_reg == FS_ERASE && cnt_reg == '0) begin
      sel_reg <= '0;
    end else if (state_reg == FS_PROT && cnt_reg == '0) begin
      sel_reg <= '0;
    end
  end

  // ******************************
  // program address and data
  // ******************************
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      arm_reg <= 1'b0;
      paddr_reg <= '0;
      pdata_reg <= '0;
    end else if (wr_take) begin
      if (arm_reg) begin
        arm_reg <= 1'b0;
        paddr_reg <= link.addr;
        pdata_reg <= cmd;
      end else if (cmd == CMD_PROGRAM &&
                   (state_reg == FS_READ || state_reg == FS_SUSP)) begin
        arm_reg <= 1'b1;
      end
    end
  end

  // ******************************
  // algorithm sequencer
  // ******************************
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= FS_READ;
      cnt_reg <= '0;
    end else begin
      if (cnt_reg != '0) begin
        cnt_reg <= cnt_reg - 1'b1;
      end
      case (state_reg)
        FS_READ: begin
          if (wr_take && arm_reg) begin
            if (prot_hit) begin
              state_reg <= FS_PROT;
              cnt_reg <= CYC_PROT_PROG;
            end else begin
              state_reg <= FS_PROG;
              cnt_reg <= CW'(PROG_CYC);
            end
          end else if (wr_take && cmd == CMD_SECT_ERASE) begin
            state_reg <= FS_ERASE_WIN;
            cnt_reg <= CYC_ERASE_WIN;
          end else if (wr_take && cmd == CMD_CHIP_ERASE) begin
            // chip erase skips the acceptance window
            state_reg <= &sector_protect ? FS_PROT : FS_ERASE;
            cnt_reg <= &sector_protect ? CYC_PROT_ERASE : CW'(ERASE_CYC);
          end
        end
        FS_ERASE_WIN: begin
          if (wr_take && cmd == CMD_SECT_ERASE) begin
            cnt_reg <= CYC_ERASE_WIN;
          end else if (cnt_reg == '0) begin
            state_reg <= all_prot ? FS_PROT : FS_ERASE;
            cnt_reg <= all_prot ? CYC_PROT_ERASE : CW'(ERASE_CYC);
          end
        end
        FS_ERASE: begin
          // everything except suspend is ignored here
          if (wr_take && cmd == CMD_SUSPEND) begin
            state_reg <= FS_SUSP;
          end else if (cnt_reg == '0) begin
            state_reg <= FS_READ;
          end
        end
        FS_SUSP: begin
          if (wr_take && arm_reg && !prot_hit) begin
            state_reg <= FS_SUSP_PROG;
            cnt_reg <= CW'(PROG_CYC);
          end else if (wr_take && cmd == CMD_RESUME) begin
            state_reg <= FS_ERASE;
          end
        end
        FS_SUSP_PROG: begin
          if (cnt_reg == '0) begin
            state_reg <= bad_prog ? FS_FAIL : FS_SUSP;
          end
        end
        FS_PROG: begin
          if (cnt_reg == '0) begin
            state_reg <= bad_prog ? FS_FAIL : FS_READ;
          end
        end
        FS_PROT: begin
          if (cnt_reg == '0) begin
            state_reg <= FS_READ;
          end
        end
        FS_FAIL: begin
          if (wr_take && cmd == CMD_RESET) begin
            state_reg <= FS_READ;
          end
        end
        default: begin
          state_reg <= FS_READ;
        end
      endcase
    end
  end

  // ******************************
  // cell array
  // ******************************
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < DEPTH; i++) begin
        arr_reg[i] <= ERASED;
      end
    end else if ((state_reg == FS_PROG || state_reg == FS_SUSP_PROG) &&
                 cnt_reg == '0 && !bad_prog) begin
      arr_reg[paddr_reg] <= pdata_reg;
    end else if (state_reg == FS_ERASE && cnt_reg == '0) begin
      for (int i = 0; i < DEPTH; i++) begin
        // protected sectors keep their contents
        if (sel_reg[i >> (AW - SECT_BITS)] &&
            !sector_protect[i >> (AW - SECT_BITS)]) begin
          arr_reg[i] <= ERASED;
        end
      end
    end
  end

  // ******************************
  // toggle bits
  // ******************************
  logic tog_run;
  logic stog_run;
  // the toggle also runs in the failed state so a host sees it stuck
  assign tog_run = state_reg != FS_READ && state_reg != FS_SUSP;
  assign stog_run = state_reg == FS_ERASE_WIN || state_reg == FS_ERASE ||
                    state_reg == FS_SUSP;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      tog_reg <= 1'b0;
      stog_reg <= 1'b0;
    end else if (rd_evt) begin
      if (tog_run) begin
        tog_reg <= ~tog_reg;
      end
      if (stog_run && in_sel) begin
        stog_reg <= ~stog_reg;
      end
    end
  end

  // ******************************
  // read data and status
  // ******************************
  logic [DW-1:0] rd_val;
  always_comb begin
    rd_val = '0;
    case (state_reg)
      FS_PROG, FS_SUSP_PROG: begin
        rd_val[BIT_POLL] = ~pdata_reg[BIT_POLL];
        rd_val[BIT_TOGGLE] = tog_reg;
      end
      FS_ERASE_WIN, FS_ERASE: begin
        rd_val[BIT_TOGGLE] = tog_reg;
        rd_val[BIT_TIMER] = state_reg == FS_ERASE;
        rd_val[BIT_SECT] = stog_reg;
      end
      FS_SUSP: begin
        if (in_sel) begin
          rd_val[BIT_POLL] = 1'b1;
          rd_val[BIT_TOGGLE] = tog_reg;
          rd_val[BIT_SECT] = stog_reg;
        end else begin
          rd_val = arr_reg[link.addr];
        end
      end
      FS_PROT: begin
        rd_val[BIT_TOGGLE] = tog_reg;
      end
      FS_FAIL: begin
        rd_val[BIT_POLL] = ~pdata_reg[BIT_POLL];
        rd_val[BIT_TOGGLE] = tog_reg;
        rd_val[BIT_FAIL] = 1'b1;
      end
      default: begin
        rd_val = arr_reg[link.addr];
      end
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      dq_reg <= '0;
      dq_oe_reg <= 1'b0;
      rb_oe_reg <= 1'b0;
      busy <= 1'b0;
      failed <= 1'b0;
    end else begin
      dq_reg <= rd_val;
      dq_oe_reg <= rd_act;
      rb_oe_reg <= tog_run;
      busy <= tog_run;
      failed <= state_reg == FS_FAIL;
    end
  end

  assign link.d_dq = dq_reg;
  assign link.d_dq_oe = dq_oe_reg;
  assign link.rb_oe = rb_oe_reg;
endmodule
`default_nettype wire

// ==== hdl/fws_host_end.sv ====
// flash controller end: register slave and toggle polling sequencer
`timescale 1ns/100ps
`default_nettype none
module fws_host_end
  import fws_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  fws_link_if.host link,
  input wire logic [1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest
);
  fws_host_e hs_reg;
  logic [1:0] op_reg;
  logic [1:0] phase_reg;
  logic [1:0] step_reg;
  logic [1:0] res_reg;
  logic [AW-1:0] addr_reg;
  logic [DW-1:0] data_reg;
  logic [DW-1:0] rd_reg;
  logic [DW-1:0] first_reg;
  logic sync_reg;
  logic ce_n_reg;
  logic oe_n_reg;
  logic we_n_reg;
  logic adv_n_reg;
  logic dq_oe_reg;
  logic seq_busy;
  logic cmd_go;
  logic toggled;

  assign seq_busy = hs_reg != HS_IDLE;
  assign cmd_go = avs_write && !avs_waitrequest && avs_address == REG_CMD &&
                  avs_writedata[17:16] != 2'h0;
  assign toggled = first_reg[BIT_TOGGLE] != rd_reg[BIT_TOGGLE];

  // ******************************
  // register slave
  // ******************************
  // a command write stalls while the link is still in use
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= '0;
      sync_reg <= 1'b0;
    end else begin
      avs_waitrequest <= 1'b1;
      if ((avs_read || avs_write) && avs_waitrequest &&
          !(avs_write && avs_address == REG_CMD && seq_busy)) begin
        avs_waitrequest <= 1'b0;
        avs_readdata <= '0;
        if (avs_address == REG_CFG) begin
          avs_readdata[0] <= sync_reg;
        end else if (avs_address == REG_STAT) begin
          // last byte carries the erase timer for software checks
          avs_readdata <= {20'h00000, res_reg, link.ready_busy_n, seq_busy,
                           rd_reg};
        end
      end
      if (avs_write && !avs_waitrequest && avs_address == REG_CFG) begin
        sync_reg <= avs_writedata[0];
      end
    end
  end

  // ******************************
  // link sequencer
  // ******************************
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      hs_reg <= HS_IDLE;
      op_reg <= '0;
      phase_reg <= '0;
      step_reg <= '0;
      res_reg <= RES_NONE;
      addr_reg <= '0;
      data_reg <= '0;
      rd_reg <= '0;
      first_reg <= '0;
      ce_n_reg <= 1'b1;
      oe_n_reg <= 1'b1;
      we_n_reg <= 1'b1;
      adv_n_reg <= 1'b1;
      dq_oe_reg <= 1'b0;
    end else begin
      case (hs_reg)
        HS_IDLE: begin
          if (cmd_go) begin
            op_reg <= avs_writedata[17:16];
            addr_reg <= avs_writedata[8 +: AW];
            data_reg <= avs_writedata[7:0];
            step_reg <= '0;
            res_reg <= RES_NONE;
            hs_reg <= HS_ACC;
            phase_reg <= '0;
            ce_n_reg <= 1'b0;
            we_n_reg <= avs_writedata[17:16] != OP_WRITE;
            oe_n_reg <= avs_writedata[17:16] == OP_WRITE;
            adv_n_reg <= !(sync_reg && avs_writedata[17:16] != OP_WRITE);
            dq_oe_reg <= avs_writedata[17:16] == OP_WRITE;
          end
        end
        HS_ACC: begin
          phase_reg <= phase_reg + 1'b1;
          adv_n_reg <= 1'b1;
          if (phase_reg == LINK_ACC_CYC - 2'h1) begin
            rd_reg <= op_reg == OP_WRITE ? rd_reg : link.dq;
            hs_reg <= HS_GAP;
            ce_n_reg <= 1'b1;
            oe_n_reg <= 1'b1;
            we_n_reg <= 1'b1;
            dq_oe_reg <= 1'b0;
          end
        end
        HS_GAP: begin
          hs_reg <= HS_IDLE;
          if (op_reg == OP_POLL) begin
            step_reg <= step_reg + 1'b1;
            hs_reg <= HS_ACC;
            phase_reg <= '0;
            ce_n_reg <= 1'b0;
            oe_n_reg <= 1'b0;
            adv_n_reg <= !sync_reg;
            if (step_reg == 2'h0 || step_reg == 2'h2) begin
              first_reg <= rd_reg;
            end else if (!toggled) begin
              res_reg <= RES_DONE;
              hs_reg <= HS_IDLE;
              ce_n_reg <= 1'b1;
              oe_n_reg <= 1'b1;
              adv_n_reg <= 1'b1;
            end else if (step_reg == 2'h1 && !rd_reg[BIT_FAIL]) begin
              res_reg <= RES_RUNNING;
              hs_reg <= HS_IDLE;
              ce_n_reg <= 1'b1;
              oe_n_reg <= 1'b1;
              adv_n_reg <= 1'b1;
            end else if (step_reg == 2'h3) begin
              // still toggling after the recheck: reset the device
              res_reg <= RES_FAILED;
              op_reg <= OP_WRITE;
              data_reg <= CMD_RESET;
              oe_n_reg <= 1'b1;
              we_n_reg <= 1'b0;
              adv_n_reg <= 1'b1;
              dq_oe_reg <= 1'b1;
            end
          end
        end
        default: begin
          hs_reg <= HS_IDLE;
        end
      endcase
    end
  end

  assign link.ce_n = ce_n_reg;
  assign link.oe_n = oe_n_reg;
  assign link.we_n = we_n_reg;
  assign link.address_valid_n = adv_n_reg;
  assign link.lclk = 1'b0;
  assign link.addr = addr_reg;
  assign link.h_dq = data_reg;
  assign link.h_dq_oe = dq_oe_reg;
endmodule
`default_nettype wire

// ==== bench/fws_props.sv ====
// link checker for the host end and device end pair
`timescale 1ns/100ps
`default_nettype none
module fws_props
  import fws_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic ce_n,
  input wire logic oe_n,
  input wire logic we_n,
  input wire logic address_valid_n,
  input wire logic [DW-1:0] dq,
  input wire logic h_dq_oe,
  input wire logic d_dq_oe,
  input wire logic rb_oe
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);
  // ******************************
  // read sampling
  // ******************************
  logic drv_q;
  logic run_q;
  logic prv_busy_q;
  logic [DW-1:0] smp_q;
  logic [DW-1:0] prv_q;
  logic rd_end;
  assign rd_end = drv_q && !d_dq_oe;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      drv_q <= 1'b0;
      smp_q <= '0;
    end else begin
      drv_q <= d_dq_oe;
      // keep what the host takes, not the byte after the flip
      if (d_dq_oe && !ce_n && !oe_n) begin
        smp_q <= dq;
      end
    end
  end
  // busy held all along, so an end of operation between reads is not judged
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      run_q <= 1'b0;
      prv_busy_q <= 1'b0;
      prv_q <= '0;
    end else begin
      run_q <= rd_end || (run_q && rb_oe);
      if (rd_end) begin
        prv_busy_q <= run_q && rb_oe;
        prv_q <= smp_q;
      end
    end
  end
  // ******************************
  // properties
  // ******************************
  sequence s_low3(logic s);
    !s [*3] ##1 s;
  endsequence
  sequence s_answer;
    d_dq_oe [*3] ##1 !d_dq_oe;
  endsequence
  property p_rd_len;
    $fell(oe_n) |-> s_low3(oe_n);
  endproperty
  property p_wr_len;
    $fell(we_n) |-> s_low3(we_n);
  endproperty
  property p_no_clash;
    !(d_dq_oe && h_dq_oe);
  endproperty
  property p_one_dir;
    !(!oe_n && !we_n);
  endproperty
  property p_drv_cause;
    d_dq_oe |-> $past(!ce_n && !oe_n);
  endproperty
  property p_drv_start;
    $fell(ce_n || oe_n) |=> s_answer;
  endproperty
  property p_adv;
    $fell(address_valid_n) |-> !ce_n ##1 address_valid_n;
  endproperty
  property p_toggle;
    rd_end && prv_busy_q && run_q && rb_oe |-> smp_q[BIT_TOGGLE] != prv_q[BIT_TOGGLE];
  endproperty
  property p_suspend;
    $rose(we_n) && $past(dq) == CMD_SUSPEND && rb_oe |-> ##[1:8] !rb_oe;
  endproperty
  a_rd_len: assert property (p_rd_len) else $error("read strobe length wrong");
  a_wr_len: assert property (p_wr_len) else $error("write strobe length wrong");
  a_no_clash: assert property (p_no_clash) else $error("both ends drive dq");
  a_one_dir: assert property (p_one_dir) else $error("read and write strobes together");
  a_drv_cause: assert property (p_drv_cause) else $error("device drives without read");
  a_drv_start: assert property (p_drv_start) else $error("device answer window wrong");
  a_adv: assert property (p_adv) else $error("address valid pulse wrong");
  a_toggle: assert property (p_toggle) else $error("toggle bit steady while busy");
  a_suspend: assert property (p_suspend) else $error("busy kept after suspend");
endmodule
`default_nettype wire

// ==== bench/tb_flash_write_status_reporting.sv ====
// self-checking bench for the host end and device end pair
`timescale 1ns/100ps
`default_nettype none
module tb_flash_write_status_reporting
  import fws_pkg::*;
;
  logic mclk;
  logic rst_n;
  logic sync_mode;
  logic [N_SECT-1:0] sect_prot;
  logic busy;
  logic failed;
  logic [1:0] avs_address;
  logic avs_read;
  logic avs_write;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [31:0] q;
  logic [7:0] r1;
  logic [7:0] r2;
  logic [1:0] res;
  int error_cnt;
  int n_compared;
  int cyc;
  int t0;
  fws_link_if link();
  fws_dev_end #(.PROG_CYC(60), .ERASE_CYC(600)) fws_dev_end_i (
    .mclk(mclk), .rst_n(rst_n), .link(link), .sync_mode(sync_mode),
    .sector_protect(sect_prot), .busy(busy), .failed(failed));
  fws_host_end fws_host_end_i (
    .mclk(mclk), .rst_n(rst_n), .link(link), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
  fws_props fws_props_i (
    .mclk(mclk), .rst_n(rst_n), .ce_n(link.ce_n), .oe_n(link.oe_n), .we_n(link.we_n),
    .address_valid_n(link.address_valid_n), .dq(link.dq), .h_dq_oe(link.h_dq_oe),
    .d_dq_oe(link.d_dq_oe), .rb_oe(link.rb_oe));
  // ******************************
  // access tasks
  // ******************************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // a spare edge after release keeps back-to-back calls from clashing
  task automatic av(input logic [1:0] a, input logic w, input logic [31:0] d);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= d;
    @(posedge mclk);
    while (avs_waitrequest !== 1'b0) @(posedge mclk);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic cmd(input logic [1:0] op, input logic [3:0] a, input logic [7:0] d);
    av(REG_CMD, 1'b1, {14'h0000, op, 4'h0, a, d});
    av(REG_STAT, 1'b0, 32'h0);
    while (q[8] !== 1'b0) av(REG_STAT, 1'b0, 32'h0);
  endtask
  task automatic lrd(input logic [3:0] a, output logic [7:0] v);
    cmd(OP_READ, a, 8'h00);
    v = q[7:0];
  endtask
  task automatic prog(input logic [3:0] a, input logic [7:0] d);
    cmd(OP_WRITE, a, CMD_PROGRAM);
    cmd(OP_WRITE, a, d);
  endtask
  task automatic tog2(input logic [3:0] a);
    lrd(a, r1);
    lrd(a, r2);
  endtask
  task automatic poll(input logic [3:0] a, output logic [1:0] r);
    r = RES_RUNNING;
    while (r === RES_RUNNING) begin
      cmd(OP_POLL, a, 8'h00);
      r = q[11:10];
    end
  endtask
  // ******************************
  // clock, timeout, tests
  // ******************************
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  initial begin
    cyc = 0;
    forever begin
      @(posedge mclk);
      cyc++;
      if (cyc == 60000) begin
        error_cnt++;
        wrap_up();
      end
    end
  end
  initial begin
    error_cnt = 0;
    n_compared = 0;
    rst_n = 1'b0;
    sync_mode = 1'b0;
    sect_prot = 4'h0;
    avs_address = 2'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    av(REG_STAT, 1'b0, 32'h0);
    chk(q[9], 1'b1);
    av(2'h3, 1'b1, 32'hFFFFFFFF);
    av(2'h3, 1'b0, 32'h0);
    chk(q, 32'h0);
    // synchronous strobing first, then asynchronous
    for (int m = 1; m >= 0; m--) begin
      sync_mode <= m[0];
      av(REG_CFG, 1'b1, {31'h0, m[0]});
      prog(4'h2 - m[3:0], 8'h5A);
      tog2(4'h2 - m[3:0]);
      chk(r1[BIT_TOGGLE], {~r2[BIT_TOGGLE]});
      chk({r1 & 8'hBF, r2 & 8'hBF}, 16'h8080);
      chk(busy, 1'b1);
      poll(4'h2 - m[3:0], res);
      chk(res, RES_DONE);
      lrd(4'h2 - m[3:0], r1);
      chk(r1, 8'h5A);
    end
    prog(4'h1, 8'hFF);
    repeat (70) @(posedge mclk);
    lrd(4'h1, r1);
    chk({r1[BIT_FAIL], failed}, 2'h3);
    poll(4'h1, res);
    chk(res, RES_FAILED);
    lrd(4'h1, r1);
    chk({r1, failed, busy}, 10'h168);
    prog(4'h4, 8'h33);
    poll(4'h4, res);
    sect_prot <= 4'h2;
    prog(4'h5, 8'h00);
    poll(4'h5, res);
    lrd(4'h5, r1);
    chk({res, r1}, {RES_DONE, ERASED});
    cmd(OP_WRITE, 4'h0, CMD_SECT_ERASE);
    lrd(4'h0, r1);
    chk(r1[BIT_TIMER], 1'b0);
    repeat (400) @(posedge mclk);
    cmd(OP_WRITE, 4'h4, CMD_SECT_ERASE);
    repeat (200) @(posedge mclk);
    lrd(4'h0, r1);
    chk(r1[BIT_TIMER], 1'b0);
    while (r1[BIT_TIMER] !== 1'b1) lrd(4'h0, r1);
    tog2(4'h0);
    chk({r1[6], r1[2]}, {~{r2[6], r2[2]}});
    chk({r2 & 8'hBB, busy}, 9'h011);
    prog(4'h9, 8'h00);
    cmd(OP_WRITE, 4'h0, CMD_SUSPEND);
    tog2(4'h0);
    chk(r1[BIT_TOGGLE], r2[BIT_TOGGLE]);
    chk(r1[BIT_SECT], {~r2[BIT_SECT]});
    chk({r1[7], r1[5], busy}, 3'h4);
    prog(4'h8, 8'h0F);
    tog2(4'h8);
    chk(r1[BIT_TOGGLE], {~r2[BIT_TOGGLE]});
    poll(4'h8, res);
    chk(res, RES_DONE);
    cmd(OP_WRITE, 4'h0, CMD_RESUME);
    poll(4'h0, res);
    lrd(4'h1, r1);
    lrd(4'h4, r2);
    chk({res, r1, r2}, {RES_DONE, ERASED, 8'h33});
    lrd(4'h9, r1);
    lrd(4'h8, r2);
    chk({r1, r2}, {ERASED, 8'h0F});
    sect_prot <= 4'h6;
    t0 = cyc;
    cmd(OP_WRITE, 4'h8, CMD_SECT_ERASE);
    tog2(4'h8);
    chk(r1[BIT_TOGGLE], {~r2[BIT_TOGGLE]});
    poll(4'h8, res);
    lrd(4'h8, r1);
    chk({res, r1, 1'(cyc - t0 > 900)}, {RES_DONE, 8'h0F, 1'b1});
    cmd(OP_WRITE, 4'h0, CMD_CHIP_ERASE);
    lrd(4'h0, r1);
    chk(r1[BIT_TIMER], 1'b1);
    poll(4'h0, res);
    lrd(4'h2, r1);
    lrd(4'h8, r2);
    chk({res, r1, r2}, {RES_DONE, ERASED, 8'h0F});
    wrap_up();
  end
endmodule
`default_nettype wire
